/* File: sgf_flags.sv */
// Greater-flag update logic with an Avalon-MM register slave
`timescale 1ns/1ps
`default_nettype none
module sgf_flags (
    input  wire logic                      CLK,            // 25 MHz clock
    input  wire logic                      RST,            // Async reset, high
    input  wire logic                      OP_VALID,       // Instruction retires now
    input  wire sgf_pkg::sgf_req_t         OP_REQ,         // Class, operands, result
    output var  logic                      LGT_FLAG,       // Logically greater
    output var  logic                      AGT_FLAG,       // Arithmetically greater
    output var  logic                      OVF_SET,        // Overflow set pulse
    output var  logic                      FLAGS_UPDATED,  // Update pulse
    input  wire logic [sgf_pkg::ADDR_W-1:0] AVS_ADDRESS,   // Byte address
    input  wire logic                      AVS_READ,       // Read request
    input  wire logic                      AVS_WRITE,      // Write request
    input  wire logic [sgf_pkg::BUS_W-1:0] AVS_WRITEDATA,  // Write data
    output var  logic [sgf_pkg::BUS_W-1:0] AVS_READDATA,   // Read data
    output var  logic                      AVS_WAITREQUEST // Stall
);

    //////////////////////////////////////////////////////////////////
    // Operand helpers

    function automatic logic msb_of(
        input logic [sgf_pkg::DATA_W-1:0] v,
        input logic                       bm
    );
        return bm ? v[sgf_pkg::BYTE_MSB] : v[sgf_pkg::WORD_MSB];
    endfunction

    function automatic logic nonzero(
        input logic [sgf_pkg::DATA_W-1:0] v,
        input logic                       bm
    );
        return bm ? (|v[sgf_pkg::BYTE_MSB:0]) : (|v);
    endfunction

    // Msb of the difference alone settles the equal-msb case
    function automatic sgf_pkg::sgf_flags_t cmp_flags(
        input logic [sgf_pkg::DATA_W-1:0] sa,
        input logic [sgf_pkg::DATA_W-1:0] da,
        input logic                       bm
    );
        logic [sgf_pkg::DATA_W-1:0] diff;
        logic                       ms;
        logic                       md;
        logic                       mx;
        sgf_pkg::sgf_flags_t        f;
        diff  = da - sa;
        ms    = msb_of(sa, bm);
        md    = msb_of(da, bm);
        mx    = msb_of(diff, bm);
        f.lgt = (ms & ~md) | ((ms == md) & mx);
        f.agt = (~ms & md) | ((ms == md) & mx);
        return f;
    endfunction

    function automatic sgf_pkg::sgf_flags_t value_flags(
        input logic [sgf_pkg::DATA_W-1:0] v,
        input logic                       bm
    );
        sgf_pkg::sgf_flags_t f;
        f.lgt = nonzero(v, bm);
        f.agt = ~msb_of(v, bm) & nonzero(v, bm);
        return f;
    endfunction

    //////////////////////////////////////////////////////////////////
    // Flag evaluation

    logic                ovf_clr_r;
    sgf_pkg::sgf_flags_t flags_nxt;
    logic                upd_nxt;
    logic                ovf_nxt;

    always_comb begin
        flags_nxt.lgt = LGT_FLAG;
        flags_nxt.agt = AGT_FLAG;
        upd_nxt       = 1'b0;
        ovf_nxt       = 1'b0;
        // Execute-indirect itself is held; its target arrives as its own op
        if (OP_VALID && !OP_REQ.exec_indirect) begin
            unique case (OP_REQ.cls)
                sgf_pkg::SGF_CLS_NONE: begin
                    upd_nxt = 1'b0;
                end
                sgf_pkg::SGF_CLS_CMP: begin
                    upd_nxt   = 1'b1;
                    flags_nxt = cmp_flags(OP_REQ.source_operand,
                                          OP_REQ.dest_operand,
                                          OP_REQ.byte_mode);
                end
                sgf_pkg::SGF_CLS_CMPI: begin
                    upd_nxt   = 1'b1;
                    flags_nxt = cmp_flags(OP_REQ.source_operand,
                                          OP_REQ.immediate_operand,
                                          1'b0);
                end
                sgf_pkg::SGF_CLS_ABSLD: begin
                    upd_nxt   = 1'b1;
                    flags_nxt = value_flags(OP_REQ.source_operand,
                                            OP_REQ.byte_mode);
                end
                sgf_pkg::SGF_CLS_RETURN,
                sgf_pkg::SGF_CLS_LOADST: begin
                    upd_nxt = 1'b1;
                    flags_nxt.lgt =
                        OP_REQ.saved_status_word_reg[sgf_pkg::SAVED_LGT_BIT];
                    flags_nxt.agt =
                        OP_REQ.saved_status_word_reg[sgf_pkg::SAVED_AGT_BIT];
                end
                sgf_pkg::SGF_CLS_RESULT: begin
                    upd_nxt = 1'b1;
                    if (OP_REQ.div_ovf) begin
                        // Flags are undefined here; policy bit picks hold or clear
                        ovf_nxt = 1'b1;
                        if (ovf_clr_r) begin
                            flags_nxt.lgt = 1'b0;
                            flags_nxt.agt = 1'b0;
                        end
                    end else begin
                        flags_nxt = value_flags(OP_REQ.result,
                                                OP_REQ.byte_mode);
                    end
                end
                default: begin
                    upd_nxt = 1'b0;
                end
            endcase
        end
    end

    // Same edge as the result write, so the next op sees new flags
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            LGT_FLAG <= 1'b0;
            AGT_FLAG <= 1'b0;
        end else begin
            LGT_FLAG <= flags_nxt.lgt;
            AGT_FLAG <= flags_nxt.agt;
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            OVF_SET       <= 1'b0;
            FLAGS_UPDATED <= 1'b0;
        end else begin
            OVF_SET       <= ovf_nxt;
            FLAGS_UPDATED <= upd_nxt;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then a one-cycle answer

    sgf_pkg::sgf_bus_state_t bus_r;
    logic                    ovf_seen_r;
    logic [15:0]             count_r;
    logic                    req;
    logic                    wr_take;
    logic                    hit_ctrl;
    logic                    hit_stat;
    logic                    hit_count;

    assign req       = AVS_READ | AVS_WRITE;
    assign wr_take   = AVS_WRITE & (bus_r == sgf_pkg::SGF_BUS_ACK);
    assign hit_ctrl  = (AVS_ADDRESS == sgf_pkg::CTRL_OFS);
    assign hit_stat  = (AVS_ADDRESS == sgf_pkg::STATUS_OFS);
    assign hit_count = (AVS_ADDRESS == sgf_pkg::COUNT_OFS);

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            bus_r           <= sgf_pkg::SGF_BUS_IDLE;
            AVS_WAITREQUEST <= 1'b1;
        end else begin
            unique case (bus_r)
                sgf_pkg::SGF_BUS_IDLE: begin
                    if (req) begin
                        bus_r           <= sgf_pkg::SGF_BUS_ACK;
                        AVS_WAITREQUEST <= 1'b0;
                    end
                end
                sgf_pkg::SGF_BUS_ACK: begin
                    bus_r           <= sgf_pkg::SGF_BUS_IDLE;
                    AVS_WAITREQUEST <= 1'b1;
                end
                default: begin
                    bus_r           <= sgf_pkg::SGF_BUS_IDLE;
                    AVS_WAITREQUEST <= 1'b1;
                end
            endcase
        end
    end

    // Read data is latched as waitrequest falls and stands through the take
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            AVS_READDATA <= '0;
        end else if (AVS_READ && bus_r == sgf_pkg::SGF_BUS_IDLE) begin
            AVS_READDATA <= '0;
            if (hit_ctrl) begin
                AVS_READDATA[sgf_pkg::CTRL_OVF_CLR_BIT] <= ovf_clr_r;
            end
            if (hit_stat) begin
                AVS_READDATA[sgf_pkg::STAT_LGT_BIT] <= LGT_FLAG;
                AVS_READDATA[sgf_pkg::STAT_AGT_BIT] <= AGT_FLAG;
                AVS_READDATA[sgf_pkg::STAT_OVF_BIT] <= ovf_seen_r;
            end
            if (hit_count) begin
                AVS_READDATA[15:0] <= count_r;
            end
        end
    end

    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ovf_clr_r <= sgf_pkg::CTRL_RESET;
        end else if (wr_take && hit_ctrl) begin
            ovf_clr_r <= AVS_WRITEDATA[sgf_pkg::CTRL_OVF_CLR_BIT];
        end
    end

    // Sticky overflow seen: write one to clear, a new overflow wins
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            ovf_seen_r <= 1'b0;
        end else if (ovf_nxt) begin
            ovf_seen_r <= 1'b1;
        end else if (wr_take && hit_stat && AVS_WRITEDATA[sgf_pkg::STAT_OVF_BIT]) begin
            ovf_seen_r <= 1'b0;
        end
    end

    // Update counter wraps; a clear in an update cycle leaves one
    always_ff @(posedge CLK or posedge RST) begin
        if (RST) begin
            count_r <= sgf_pkg::COUNT_RESET;
        end else if (wr_take && hit_count) begin
            count_r <= upd_nxt ? sgf_pkg::COUNT_ONE : sgf_pkg::COUNT_RESET;
        end else if (upd_nxt) begin
            count_r <= count_r + sgf_pkg::COUNT_ONE;
        end
    end

    //////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    logic       go;
    logic [7:0] s8;
    logic [7:0] d8;
    logic [7:0] i8;
    assign go = OP_VALID && !OP_REQ.exec_indirect;
    assign s8 = OP_REQ.source_operand[7:0];
    assign d8 = OP_REQ.dest_operand[7:0];
    assign i8 = OP_REQ.immediate_operand[7:0];

    cmp_word_a: assert property (
        go && OP_REQ.cls == sgf_pkg::SGF_CLS_CMP && !OP_REQ.byte_mode |=>
        LGT_FLAG == ($past(OP_REQ.source_operand) > $past(OP_REQ.dest_operand)) &&
        AGT_FLAG == ($signed($past(OP_REQ.source_operand)) >
                     $signed($past(OP_REQ.dest_operand))))
        else $error("word compare flags wrong");

    cmp_byte_a: assert property (
        go && OP_REQ.cls == sgf_pkg::SGF_CLS_CMP && OP_REQ.byte_mode |=>
        LGT_FLAG == ($past(s8) > $past(d8)) &&
        AGT_FLAG == ($signed($past(s8)) > $signed($past(d8))))
        else $error("byte compare flags wrong");

    cmp_imm_a: assert property (
        go && OP_REQ.cls == sgf_pkg::SGF_CLS_CMPI |=>
        LGT_FLAG == ($past(OP_REQ.source_operand) > $past(OP_REQ.immediate_operand)) &&
        AGT_FLAG == ($signed($past(OP_REQ.source_operand)) >
                     $signed($past(OP_REQ.immediate_operand))))
        else $error("immediate compare flags wrong");

    abs_load_a: assert property (
        go && OP_REQ.cls == sgf_pkg::SGF_CLS_ABSLD && !OP_REQ.byte_mode |=>
        LGT_FLAG == ($past(OP_REQ.source_operand) != 16'h0000) &&
        AGT_FLAG == ($signed($past(OP_REQ.source_operand)) > 16'sh0000))
        else $error("abs or serial load flags wrong");

    saved_load_a: assert property (
        go && (OP_REQ.cls == sgf_pkg::SGF_CLS_RETURN ||
               OP_REQ.cls == sgf_pkg::SGF_CLS_LOADST) |=>
        {LGT_FLAG, AGT_FLAG} == $past(OP_REQ.saved_status_word_reg[15:14]))
        else $error("status load flags wrong");

    result_word_a: assert property (
        go && OP_REQ.cls == sgf_pkg::SGF_CLS_RESULT && !OP_REQ.div_ovf &&
        !OP_REQ.byte_mode |=>
        LGT_FLAG == ($past(OP_REQ.result) != 16'h0000) &&
        AGT_FLAG == ($signed($past(OP_REQ.result)) > 16'sh0000))
        else $error("result flags wrong");

    hold_flags_a: assert property (
        !go || OP_REQ.cls == sgf_pkg::SGF_CLS_NONE |=>
        $stable(LGT_FLAG) && $stable(AGT_FLAG) && !FLAGS_UPDATED)
        else $error("flags changed without an update");

    div_ovf_a: assert property (
        go && OP_REQ.cls == sgf_pkg::SGF_CLS_RESULT && OP_REQ.div_ovf |=>
        OVF_SET ##1 ovf_seen_r)
        else $error("divide overflow not raised");

    rst_clear_a: assert property (disable iff (1'b0)
        RST |-> !LGT_FLAG && !AGT_FLAG)
        else $error("flags not cleared in reset");

    bus_answer_a: assert property (
        req && AVS_WAITREQUEST |-> ##[0:1] !AVS_WAITREQUEST ##1 AVS_WAITREQUEST)
        else $error("bus answer not one cycle");

    // Byte operands sit right-justified; only bits 7:0 take part
    logic [7:0] r8;
    assign r8 = OP_REQ.result[7:0];

    abs_byte_a: assert property (
        go && OP_REQ.cls == sgf_pkg::SGF_CLS_ABSLD && OP_REQ.byte_mode |=>
        LGT_FLAG == ($past(s8) != 8'h00) &&
        AGT_FLAG == ($signed($past(s8)) > 8'sh00))
        else $error("byte abs or serial load flags wrong");

    result_byte_a: assert property (
        go && OP_REQ.cls == sgf_pkg::SGF_CLS_RESULT && !OP_REQ.div_ovf &&
        OP_REQ.byte_mode |=>
        LGT_FLAG == ($past(r8) != 8'h00) &&
        AGT_FLAG == ($signed($past(r8)) > 8'sh00))
        else $error("byte result flags wrong");

    illegal_hold_a: assert property (
        go && OP_REQ.cls == sgf_pkg::sgf_class_t'(3'h7) |=>
        $stable(LGT_FLAG) && $stable(AGT_FLAG) && !FLAGS_UPDATED)
        else $error("illegal class changed the flags");

    update_pulse_a: assert property (
        go && OP_REQ.cls != sgf_pkg::SGF_CLS_NONE &&
        OP_REQ.cls != sgf_pkg::sgf_class_t'(3'h7) |=> FLAGS_UPDATED)
        else $error("update pulse missing");

    ovf_quiet_a: assert property (
        !(go && OP_REQ.cls == sgf_pkg::SGF_CLS_RESULT && OP_REQ.div_ovf) |=> !OVF_SET)
        else $error("overflow pulse without a divide overflow");

    // Undefined flags after a divide overflow follow the policy bit
    ovf_clear_a: assert property (
        go && OP_REQ.cls == sgf_pkg::SGF_CLS_RESULT && OP_REQ.div_ovf && ovf_clr_r |=>
        !LGT_FLAG && !AGT_FLAG)
        else $error("overflow did not clear the flags");

    ovf_hold_a: assert property (
        go && OP_REQ.cls == sgf_pkg::SGF_CLS_RESULT && OP_REQ.div_ovf && !ovf_clr_r |=>
        $stable(LGT_FLAG) && $stable(AGT_FLAG))
        else $error("overflow changed the held flags");

    sticky_set_a: assert property (
        OVF_SET |-> ovf_seen_r)
        else $error("overflow pulse without sticky bit");

    // Status read data is the flag state seen in the wait cycle, one cycle before the take
    status_read_a: assert property (
        AVS_READ && AVS_WAITREQUEST && hit_stat |=>
        AVS_READDATA[sgf_pkg::STAT_LGT_BIT] == $past(LGT_FLAG) &&
        AVS_READDATA[sgf_pkg::STAT_AGT_BIT] == $past(AGT_FLAG) &&
        AVS_READDATA[sgf_pkg::STAT_OVF_BIT] == $past(ovf_seen_r))
        else $error("status read data wrong");

endmodule
`default_nettype wire

/* File: sgf_pkg.sv */
// Constants and types for the status greater-flag logic
//////////////////////////////////////////////////////////////////////
package sgf_pkg;

    localparam int DATA_W = 16;
    localparam int ADDR_W = 4;
    localparam int BUS_W  = 32;

    localparam logic [3:0]  CTRL_OFS    = 4'h0;
    localparam logic [3:0]  STATUS_OFS  = 4'h4;
    localparam logic [3:0]  COUNT_OFS   = 4'h8;
    localparam int          CTRL_OVF_CLR_BIT = 0;
    localparam int          STAT_LGT_BIT     = 0;
    localparam int          STAT_AGT_BIT     = 1;
    localparam int          STAT_OVF_BIT     = 2;
    localparam logic        CTRL_RESET  = 1'h0;
    localparam logic [15:0] COUNT_RESET = 16'h0000;
    localparam logic [15:0] COUNT_ONE   = 16'h0001;

    // Bit numbering of the status word counts from the msb
    localparam int WORD_MSB      = 15;
    localparam int BYTE_MSB      = 7;
    localparam int SAVED_LGT_BIT = WORD_MSB - 0;
    localparam int SAVED_AGT_BIT = WORD_MSB - 1;

    typedef enum logic [2:0] {
        SGF_CLS_NONE   = 3'h0,
        SGF_CLS_CMP    = 3'h1,
        SGF_CLS_CMPI   = 3'h2,
        SGF_CLS_ABSLD  = 3'h3,
        SGF_CLS_RETURN = 3'h4,
        SGF_CLS_LOADST = 3'h5,
        SGF_CLS_RESULT = 3'h6
    } sgf_class_t;

    typedef struct packed {
        sgf_class_t        cls;
        logic              byte_mode;
        logic              exec_indirect;
        logic              div_ovf;
        logic [DATA_W-1:0] source_operand;
        logic [DATA_W-1:0] dest_operand;
        logic [DATA_W-1:0] immediate_operand;
        logic [DATA_W-1:0] saved_status_word_reg;
        logic [DATA_W-1:0] result;
    } sgf_req_t;

    typedef struct packed {
        logic lgt;
        logic agt;
    } sgf_flags_t;

    typedef enum logic [1:0] {
        SGF_BUS_IDLE = 2'b01,
        SGF_BUS_ACK  = 2'b10
    } sgf_bus_state_t;

endpackage

/* File: sgf_seq_model.sv */
// Behavioural model of the instruction sequencer that retires ops into the flag block
`timescale 1ns/1ps
`default_nettype none
module sgf_seq_model (
    input  wire logic              clk,      // Processor clock
    input  wire logic              rst,      // Async reset, high
    input  wire logic              issue,    // Retire the staged op at the next edge
    input  wire sgf_pkg::sgf_req_t req_in,   // Staged op
    output var  logic              op_valid, // One-cycle retire strobe
    output var  sgf_pkg::sgf_req_t op_req    // Op fields seen by the block
);
    initial op_valid = 1'b0;
    initial op_req = '0;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            op_valid <= 1'b0;
        end else begin
            op_valid <= issue;
            // Idle cycles invert the fields so they keep changing while op_valid is low
            op_req <= issue ? req_in : ~op_req;
        end
    end
endmodule
`default_nettype wire

/* File: status_greater_flag_logic_test.sv */
// Self-checking bench for the greater-flag block
`timescale 1ns/1ps
`default_nettype none
module status_greater_flag_logic_test;
    logic                          clk, rst, issue, op_valid, lgt, agt, ovf_set, upd;
    sgf_pkg::sgf_req_t             req, op_req;
    logic [sgf_pkg::ADDR_W-1:0]    avs_address;
    logic                          avs_read, avs_write, avs_waitrequest;
    logic [sgf_pkg::BUS_W-1:0]     avs_writedata, avs_readdata;
    int                            errors, checks, cnt;
    logic [4:0]                    note_q[$];
    logic [31:0]                   rd_q[$];
    logic                          exp_lgt, exp_agt, exp_sticky, ctrl_clr, seen;
    logic [4:0]                    n;
    logic [15:0]                   mk;

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end

    sgf_seq_model seq (.clk(clk), .rst(rst), .issue(issue), .req_in(req), .op_valid(op_valid),
        .op_req(op_req));
    sgf_flags dut (.CLK(clk), .RST(rst), .OP_VALID(op_valid), .OP_REQ(op_req), .LGT_FLAG(lgt),
        .AGT_FLAG(agt), .OVF_SET(ovf_set), .FLAGS_UPDATED(upd), .AVS_ADDRESS(avs_address),
        .AVS_READ(avs_read), .AVS_WRITE(avs_write), .AVS_WRITEDATA(avs_writedata),
        .AVS_READDATA(avs_readdata), .AVS_WAITREQUEST(avs_waitrequest));

    //////////////////////////////////////////////////////////////////////
    task automatic chk_flag(string nm, logic e, logic g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
        checks++;
        if (g !== e) begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic report_and_stop;
        if (errors == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask

    function automatic logic [1:0] ref_flags(sgf_pkg::sgf_req_t q);
        logic [15:0] a, b, d;
        int          m;
        logic        nz;
        m = q.byte_mode ? 7 : 15;
        a = q.source_operand;
        b = q.dest_operand;
        if (q.exec_indirect) return {exp_lgt, exp_agt};
        if (q.cls == sgf_pkg::SGF_CLS_CMPI) begin
            m = 15;
            b = q.immediate_operand;
        end
        if (q.cls == sgf_pkg::SGF_CLS_RESULT) a = q.result;
        d = b - a;
        nz = q.byte_mode ? (a[7:0] != 8'h00) : (a != 16'h0000);
        case (q.cls)
            sgf_pkg::SGF_CLS_CMP, sgf_pkg::SGF_CLS_CMPI:
                return {(a[m] & !b[m]) | (a[m] == b[m] & d[m]),
                        (!a[m] & b[m]) | (a[m] == b[m] & d[m])};
            sgf_pkg::SGF_CLS_ABSLD, sgf_pkg::SGF_CLS_RESULT: begin
                if (q.div_ovf && q.cls == sgf_pkg::SGF_CLS_RESULT)
                    return ctrl_clr ? 2'b00 : {exp_lgt, exp_agt};
                return {nz, nz & !a[m]};
            end
            sgf_pkg::SGF_CLS_RETURN, sgf_pkg::SGF_CLS_LOADST:
                return {q.saved_status_word_reg[sgf_pkg::SAVED_LGT_BIT],
                        q.saved_status_word_reg[sgf_pkg::SAVED_AGT_BIT]};
            default: return {exp_lgt, exp_agt};
        endcase
    endfunction

    // Stages one op and notes its outcome; the caller lowers issue with idle()
    task automatic op(sgf_pkg::sgf_class_t c, logic bm, logic xi, logic dv,
                      logic [15:0] s, logic [15:0] d, logic [15:0] i,
                      logic [15:0] w, logic [15:0] r);
        sgf_pkg::sgf_req_t q;
        logic [1:0]        f;
        logic              acc;
        q = {c, bm, xi, dv, s, d, i, w, r};
        f = ref_flags(q);
        acc = !xi && c != sgf_pkg::SGF_CLS_NONE && c != sgf_pkg::sgf_class_t'(3'h7);
        note_q.push_back({!dv, f, dv & acc, acc});
        {exp_lgt, exp_agt} = f;
        if (dv && acc) exp_sticky = 1'b1;
        if (acc) cnt++;
        issue <= 1'b1;
        req <= q;
        @(posedge clk);
    endtask

    task automatic idle(int k);
        issue <= 1'b0;
        repeat (k) @(posedge clk);
    endtask

    task automatic bus(logic wr, logic [3:0] a, logic [31:0] wd, logic [31:0] er);
        avs_address <= a;
        avs_writedata <= wd;
        avs_write <= wr;
        avs_read <= !wr;
        if (!wr) rd_q.push_back(er);
        // Only the watchdog ends a wait that never gets its answer
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        avs_write <= 1'b0;
        avs_read <= 1'b0;
        @(posedge clk);
    endtask

    //////////////////////////////////////////////////////////////////////
    // Monitor: sample strobes and read data at the edge, flag outputs once that edge has landed
    always @(posedge clk) begin
        if (avs_read && avs_waitrequest === 1'b0) begin
            chk_word("readdata", rd_q.pop_front(), avs_readdata);
        end
        seen = op_valid;
        #1;
        if (seen === 1'b1) begin
            n = note_q.pop_front();
            chk_flag("lgt", n[3], lgt);
            chk_flag("agt", n[2], agt);
            chk_flag("ovf_set", n[1], ovf_set);
            chk_flag("updated", n[0], upd);
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        report_and_stop();
    end

    initial begin
        {issue, req, avs_address, avs_read, avs_write, avs_writedata} = '0;
        {errors, checks, cnt} = '0;
        {exp_lgt, exp_agt, exp_sticky, ctrl_clr} = '0;
        rst = 1'b1;
        void'($urandom(72804));
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk_flag("lgt_reset", 1'b0, lgt);
        chk_flag("agt_reset", 1'b0, agt);
        op(sgf_pkg::SGF_CLS_CMP, 0, 0, 0, 16'h0005, 16'h0003, 0, 0, 0);
        op(sgf_pkg::SGF_CLS_CMP, 0, 0, 0, 16'h8000, 16'h0001, 0, 0, 0);
        op(sgf_pkg::SGF_CLS_CMP, 1, 0, 0, 16'h0080, 16'h0001, 0, 0, 0);
        op(sgf_pkg::SGF_CLS_CMPI, 0, 0, 0, 16'h0001, 0, 16'h8000, 0, 0);
        op(sgf_pkg::SGF_CLS_ABSLD, 0, 0, 0, 16'h8001, 0, 0, 0, 0);
        op(sgf_pkg::SGF_CLS_ABSLD, 1, 0, 0, 16'hFF00, 0, 0, 0, 0);
        op(sgf_pkg::SGF_CLS_RETURN, 0, 0, 0, 0, 0, 0, 16'h8000, 0);
        op(sgf_pkg::SGF_CLS_LOADST, 0, 0, 0, 0, 0, 0, 16'h4000, 0);
        op(sgf_pkg::SGF_CLS_RESULT, 0, 0, 0, 0, 0, 0, 0, 16'h7FFF);
        op(sgf_pkg::SGF_CLS_RESULT, 0, 1, 0, 0, 0, 0, 0, 16'h0000);
        op(sgf_pkg::SGF_CLS_NONE, 0, 0, 0, 0, 0, 0, 0, 16'h0000);
        op(sgf_pkg::sgf_class_t'(3'h7), 0, 0, 0, 16'h1234, 0, 0, 0, 16'h1234);
        op(sgf_pkg::SGF_CLS_RESULT, 1, 0, 0, 0, 0, 0, 0, 16'h0080);
        op(sgf_pkg::SGF_CLS_RESULT, 0, 0, 1, 0, 0, 0, 0, 16'h0000);
        for (int k = 0; k < 300; k++) begin
            mk = ($urandom_range(1) == 1) ? 16'h00FF : 16'hFFFF;
            op(sgf_pkg::sgf_class_t'(3'($urandom_range(6))), mk[8] == 1'b0,
               $urandom_range(7) == 0, 0,
               16'($urandom) & mk, 16'($urandom) & mk, 16'($urandom), 16'($urandom),
               16'($urandom) & mk);
            if (k % 37 == 0) idle(2);
        end
        idle(3);
        bus(0, sgf_pkg::STATUS_OFS, 0, {29'h0, exp_sticky, exp_agt, exp_lgt});
        bus(1, sgf_pkg::STATUS_OFS, 32'h0000_0004, 0);
        bus(0, sgf_pkg::STATUS_OFS, 0, {29'h0, 1'b0, exp_agt, exp_lgt});
        bus(1, sgf_pkg::CTRL_OFS, 32'h0000_0001, 0);
        ctrl_clr = 1'b1;
        bus(1, 4'hC, 32'hFFFF_FFFF, 0);
        bus(0, 4'hC, 0, 32'h0000_0000);
        bus(0, sgf_pkg::CTRL_OFS, 0, 32'h0000_0001);
        op(sgf_pkg::SGF_CLS_RESULT, 0, 0, 0, 0, 0, 0, 0, 16'h0001);
        op(sgf_pkg::SGF_CLS_RESULT, 0, 0, 1, 0, 0, 0, 0, 16'h0000);
        idle(3);
        bus(1, sgf_pkg::COUNT_OFS, 0, 0);
        cnt = 0;
        op(sgf_pkg::SGF_CLS_CMP, 0, 0, 0, 16'h0002, 16'h0001, 0, 0, 0);
        op(sgf_pkg::SGF_CLS_NONE, 0, 0, 0, 0, 0, 0, 0, 0);
        op(sgf_pkg::SGF_CLS_LOADST, 0, 0, 0, 0, 0, 0, 16'hC000, 0);
        idle(3);
        bus(0, sgf_pkg::COUNT_OFS, 0, 32'(cnt));
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        chk_flag("lgt_midreset", 1'b0, lgt);
        chk_flag("agt_midreset", 1'b0, agt);
        rst <= 1'b0;
        {exp_lgt, exp_agt, exp_sticky, ctrl_clr} = '0;
        @(posedge clk);
        op(sgf_pkg::SGF_CLS_NONE, 0, 0, 0, 0, 0, 0, 0, 0);
        op(sgf_pkg::SGF_CLS_CMPI, 0, 0, 0, 16'h8000, 0, 16'h0001, 0, 0);
        idle(3);
        report_and_stop();
    end
endmodule
`default_nettype wire
